// ### design/fsepc_ctrl.sv
`timescale 1ns/100ps
// Operation
// - check three error flags after ready
// - clear command 50h removes error flags
// - hold reset low during power-up
// - write FFh to return to array read
// - clear status after vpp flag before more
// - back to back ops, poll each completion
module fsepc_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // user side
    input wire logic req_valid,
    input wire fsepc_pkg::fsepc_req_t req,
    output logic req_ready,
    output fsepc_pkg::fsepc_rsp_t rsp,
    // flash pins
    output logic [17:0] fl_addr,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_reset_powerdown_n
);
    import fsepc_pkg::*;

    typedef enum logic [3:0] {
        S_PWRUP = 4'b0000,
        S_REC = 4'b0001,
        S_IDLE = 4'b0010,
        S_WR = 4'b0011,
        S_GAP = 4'b0100,
        S_POLL = 4'b0101,
        S_ARRAY = 4'b0110,
        S_DEEP = 4'b0111
    } fsepc_state_t;

    fsepc_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [1:0] step_r;
    fsepc_req_t cur_r;
    logic [15:0] sync1_r, sync2_r, sync3_r;
    logic [7:0] stat_r;
    logic vpp_seen_r;
    logic [15:0] wr_data;
    logic cnt_zero;
    // order accepted at this edge
    logic take;
    // order answered at once, no bus cycles
    logic refuse;

    function automatic fsepc_err_t classify(input logic [7:0] s);
        if (s[ERASE_FAIL_BIT] && s[PROGRAM_FAIL_BIT])
            return FSEPC_ERR_SEQUENCE;
        else if (s[ERASE_FAIL_BIT])
            return FSEPC_ERR_ERASE;
        else if (s[PROGRAM_FAIL_BIT])
            return FSEPC_ERR_PROGRAM;
        else if (s[VPP_MISSING_BIT])
            return FSEPC_ERR_VPP;
        else
            return FSEPC_ERR_NONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // command stream per program or erase order: setup, second cycle, then FFh
    assign cnt_zero = (cnt_r == '0);
    // order taken only while ready is shown to the user
    assign take = req_valid && req_ready && (st_r == S_IDLE);
    // program or erase refused while a vpp error stands
    // the user must send a clear order or a power-down first; no strobe or select reaches the pins
    assign refuse = take && vpp_seen_r && (req.op == FSEPC_OP_PROGRAM || req.op == FSEPC_OP_ERASE);
    // clear order writes 50h, then FFh; FFh closes every program, erase and clear op that is not refused
    // step 2 is the read-array write, shared by program, erase and clear orders
    assign wr_data = (step_r == 2'd0) ?
        ((cur_r.op == FSEPC_OP_PROGRAM) ? {8'h00, CMD_PROGRAM_SETUP} :
         (cur_r.op == FSEPC_OP_ERASE) ? {8'h00, CMD_ERASE_SETUP} : {8'h00, CMD_CLEAR_STATUS}) :
        (step_r == 2'd1) ? ((cur_r.op == FSEPC_OP_ERASE) ? {8'h00, CMD_ERASE_CONFIRM} : cur_r.data) :
        {8'h00, CMD_READ_ARRAY};

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_PWRUP: if (cnt_zero) st_nxt = S_REC;
            S_REC: if (cnt_zero) st_nxt = S_IDLE;
            S_IDLE: begin
                if (refuse)
                    st_nxt = S_ARRAY;
                else if (take)
                    st_nxt = (req.op == FSEPC_OP_POWERDOWN) ? S_DEEP : S_WR;
            end
            S_WR: if (cnt_zero) st_nxt = S_GAP;
            S_GAP: begin
                if (cnt_zero) begin
                    if (step_r == 2'd2) st_nxt = S_ARRAY;
                    else if (step_r == 2'd1) st_nxt = S_POLL;
                    else st_nxt = S_WR;
                end
            end
            // ready bit low means busy, keep polling
            S_POLL: if (cnt_zero && sync3_r[ENGINE_READY_BIT] && sync2_r[ENGINE_READY_BIT]) st_nxt = S_WR;
            S_ARRAY: st_nxt = S_IDLE;
            // wake only after the reset pin has been low for its minimum width
            S_DEEP: if (cnt_zero && req_valid && req.op != FSEPC_OP_POWERDOWN) st_nxt = S_REC;
            default: st_nxt = S_PWRUP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= S_PWRUP;
            cnt_r <= CNT_W'(RESET_LOW_CYC);
            // idle bus shows the read-array code
            step_r <= 2'd2;
            cur_r <= '0;
            stat_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (st_nxt != st_r)
                cnt_r <= (st_nxt == S_WR) ? CNT_W'(STROBE_CYC) :
                         (st_nxt == S_REC) ? CNT_W'(RESET_REC_CYC) :
                         (st_nxt == S_DEEP) ? CNT_W'(RESET_LOW_CYC) : CNT_W'(ACCESS_CYC);
            else if (!cnt_zero)
                cnt_r <= cnt_r - 1'b1;
            if (take) begin
                cur_r <= req;
                step_r <= 2'd0;
            // clear has no second cycle, go straight to read array
            end else if (st_r == S_GAP && cnt_zero && step_r == 2'd0 && cur_r.op == FSEPC_OP_CLEAR)
                step_r <= 2'd2;
            else if (st_r == S_GAP && cnt_zero && step_r == 2'd0)
                step_r <= 2'd1;
            else if (st_r == S_POLL && st_nxt == S_WR) begin
                // capture flags once ready shows completion
                stat_r <= sync3_r[7:0];
                step_r <= 2'd2;
            end
            if (st_r == S_REC) stat_r <= 8'h00;
        end
    end

    // pin input synchroniser, three stages
    always_ff @(posedge clk_sys) begin
        sync1_r <= fl_dq_in;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pin and user outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // reset pin held low while power settles
            fl_reset_powerdown_n <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            fl_dq_out <= 16'h0000;
            fl_addr <= 18'h0_0000;
            req_ready <= 1'b0;
            rsp <= '0;
            vpp_seen_r <= 1'b0;
        end else begin
            // deep power-down drives the reset pin low
            fl_reset_powerdown_n <= !(st_nxt == S_PWRUP || st_nxt == S_DEEP);
            // chip select off outside bus cycles; engine keeps running
            fl_ce_n <= !(st_nxt == S_WR || st_nxt == S_POLL);
            fl_we_n <= !(st_nxt == S_WR);
            fl_oe_n <= !(st_nxt == S_POLL);
            fl_dq_oe <= (st_nxt == S_WR);
            fl_dq_out <= wr_data;
            // address settles with the first strobe cycle, not one later
            fl_addr <= take ? req.addr : cur_r.addr;
            // ready follows done by a cycle so the two never coincide
            req_ready <= (st_nxt == S_IDLE) && (st_r != S_ARRAY);
            // power-down is answered as soon as the pin goes low
            rsp.done <= (st_r == S_ARRAY) || (take && req.op == FSEPC_OP_POWERDOWN);
            if (st_r == S_ARRAY) begin
                rsp.status <= stat_r;
                rsp.err <= classify(stat_r);
                // any of three flags means failure
                rsp.fail <= stat_r[ERASE_FAIL_BIT] | stat_r[PROGRAM_FAIL_BIT] | stat_r[VPP_MISSING_BIT];
                // vpp error remembered until a clear order or a device reset
                vpp_seen_r <= stat_r[VPP_MISSING_BIT] && cur_r.op != FSEPC_OP_CLEAR;
            end
            // a clear order or a device reset both drop the vpp error
            if ((take && req.op == FSEPC_OP_CLEAR) || st_r == S_REC) vpp_seen_r <= 1'b0;
        end
    end

    // next order only after completion, one at a time
    a_single_order: assert property (@(posedge clk_sys) disable iff (rst)
        rsp.done |-> !req_ready) else $error("done with ready high");
    a_reset_pin_low: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == S_DEEP) |-> !fl_reset_powerdown_n) else $error("deep powerdown pin high");
    // no write strobe while vpp error stands
    a_vpp_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        vpp_seen_r |-> fl_we_n) else $error("write issued with vpp error");
    a_strobe_cs: assert property (@(posedge clk_sys) disable iff (rst)
        !fl_we_n |-> !fl_ce_n && fl_oe_n) else $error("write strobe without select");
    a_fail_flags: assert property (@(posedge clk_sys) disable iff (rst)
        rsp.done |-> rsp.fail == (rsp.status[5:3] != 3'b000)) else $error("fail mismatch");
    a_class_seq: assert property (@(posedge clk_sys) disable iff (rst)
        rsp.done && rsp.status[5] && rsp.status[4] |-> rsp.err == FSEPC_ERR_SEQUENCE)
        else $error("sequence class wrong");
    a_return_array: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rsp.done) |-> $past(fl_dq_out, 4) == 16'h00FF || $past(fl_dq_out, 3) == 16'h00FF)
        else $error("no read array before done");
endmodule

// ### design/fsepc_pkg.sv
package fsepc_pkg;
    // command codes written on the low data byte
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    // status bit positions
    localparam int ENGINE_READY_BIT = 7;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int PROGRAM_FAIL_BIT = 4;
    localparam int VPP_MISSING_BIT = 3;
    // timing, 25 MHz clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_NS = 120;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LOW_NS = 150;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_REC_NS = 1000;
    localparam int RESET_REC_CYC = (RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // error classification
    typedef enum logic [2:0] {
        FSEPC_ERR_NONE = 3'b000,
        FSEPC_ERR_VPP = 3'b001,
        FSEPC_ERR_PROGRAM = 3'b010,
        FSEPC_ERR_ERASE = 3'b011,
        FSEPC_ERR_SEQUENCE = 3'b100
    } fsepc_err_t;

    // user order
    typedef enum logic [1:0] {
        FSEPC_OP_PROGRAM = 2'b00,
        FSEPC_OP_ERASE = 2'b01,
        FSEPC_OP_CLEAR = 2'b10,
        FSEPC_OP_POWERDOWN = 2'b11
    } fsepc_op_t;

    typedef struct packed {
        fsepc_op_t op;
        logic [17:0] addr;
        logic [15:0] data;
    } fsepc_req_t;

    typedef struct packed {
        logic done;
        logic fail;
        fsepc_err_t err;
        logic [7:0] status;
    } fsepc_rsp_t;
endpackage

// ### tb/fsepc_flash_model.sv
`timescale 1ns/100ps
// behavioural flash device; the clock samples its pins and paces its timer
module fsepc_flash_model
    import fsepc_pkg::*;
#(parameter int BUSY_CYC = 20) (
    // timer clock
    input wire logic clk_sys,
    // device pins
    input wire logic [15:0] dq_out,
    input wire logic we_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic pd_n,
    output logic [15:0] dq_in,
    // test controls
    input wire logic vpp_ok,
    input wire logic fail_next,
    output logic array_mode
);
    logic [2:0] fl; // erase, program, vpp
    logic [1:0] mode; // array, status, program setup, erase setup
    logic [7:0] bcnt;
    logic ers;
    logic we_q;
    logic [15:0] wd;
    logic [15:0] last;
    wire rd = !ce_n && !oe_n && pd_n;
    wire [7:0] sr = {bcnt == 0, 1'b0, fl, 3'b000};
    wire [7:0] cmd = wd[7:0];
    ////////////////////////////////////////////////////////////////
    // standby drives the inverted last read value, busy reads status
    assign dq_in = rd ? ((mode == 0 && bcnt == 0) ? 16'hA5C3 : {8'h00, sr}) : ~last;
    assign array_mode = mode == 0;
    ////////////////////////////////////////////////////////////////
    // data latched while strobe low, since it may move once strobe rises
    always @(posedge clk_sys) begin
        we_q <= we_n;
        if (rd) last <= dq_in;
        if (!we_n) wd <= dq_out;
        if (!pd_n) begin
            fl <= 3'b000;
            mode <= 2'h0;
            bcnt <= 8'h00;
            last <= 16'h5A5A;
        // engine ignores select, fails on request
        end else if (bcnt != 0) begin
            bcnt <= bcnt - 8'h01;
            if (bcnt == 1 && fail_next) fl[ers ? 2 : 1] <= 1'b1;
        end else if (we_n && !we_q) begin
            mode <= 2'h1;
            if (mode >= 2) begin
                if (mode == 3 && cmd != CMD_ERASE_CONFIRM) fl[2:1] <= 2'b11;
                else if (!fl[0] && !vpp_ok) fl[0] <= 1'b1;
                else if (!fl[0]) begin
                    bcnt <= BUSY_CYC[7:0];
                    ers <= mode == 3;
                end
            end else if (cmd == CMD_PROGRAM_SETUP) mode <= 2'h2;
            else if (cmd == CMD_ERASE_SETUP) mode <= 2'h3;
            else if (cmd == CMD_READ_ARRAY) mode <= 2'h0;
            else if (cmd == CMD_CLEAR_STATUS) fl <= 3'b000;
        end
    end
endmodule

// ### tb/flash_status_error_power_control_tb.sv
`timescale 1ns/100ps
module flash_status_error_power_control_tb;
    import fsepc_pkg::*;
    logic clk_sys = 0, rst = 1, req_valid = 0, vpp_ok = 1, fail_next = 0;
    fsepc_req_t req = '0;
    fsepc_rsp_t rsp;
    logic req_ready, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_pd_n, array_mode;
    logic [17:0] fl_addr;
    logic [15:0] fl_dq_out, fl_dq_in;
    int n_mismatch = 0, checks = 0;
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    fsepc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp(rsp), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
        .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_powerdown_n(fl_pd_n));
    fsepc_flash_model model (.clk_sys(clk_sys), .dq_out(fl_dq_out), .we_n(fl_we_n), .ce_n(fl_ce_n),
        .oe_n(fl_oe_n), .pd_n(fl_pd_n), .dq_in(fl_dq_in), .vpp_ok(vpp_ok), .fail_next(fail_next),
        .array_mode(array_mode));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string name, logic [17:0] exp, logic [17:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // offer one order, hold it until taken, then wait for done
    task automatic run(fsepc_op_t op);
        int i;
        @(negedge clk_sys);
        req_valid = 1;
        req = '{op: op, addr: 18'h0_0100, data: 16'h1234};
        for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk_sys);
        if (i == 100) begin
            n_mismatch++;
            finish_test();
        end
        @(negedge clk_sys);
        req_valid = 0;
        for (i = 0; i < 3000 && rsp.done !== 1'b1; i++) @(negedge clk_sys);
        if (i == 3000) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_prog_ok;
        run(FSEPC_OP_PROGRAM);
        chk("status", 16'h0080, rsp.status);
        chk("err", FSEPC_ERR_NONE, rsp.err);
        chk("array_mode", 1'h1, array_mode);
        chk("ce_n", 1'h1, fl_ce_n);
        chk("we_n", 1'h1, fl_we_n);
        chk("oe_n", 1'h1, fl_oe_n);
        chk("dq_oe", 1'h0, fl_dq_oe);
        chk("addr", 18'h0_0100, fl_addr);
    endtask
    task automatic t_prog_fail;
        fail_next = 1;
        run(FSEPC_OP_PROGRAM);
        chk("err", FSEPC_ERR_PROGRAM, rsp.err);
        chk("fail", 1'h1, rsp.fail);
        fail_next = 0;
        run(FSEPC_OP_PROGRAM);
        chk("status", 16'h0090, rsp.status);
        run(FSEPC_OP_CLEAR);
        run(FSEPC_OP_PROGRAM);
        chk("status", 16'h0080, rsp.status);
    endtask
    task automatic t_vpp;
        vpp_ok = 0;
        run(FSEPC_OP_PROGRAM);
        chk("err", FSEPC_ERR_VPP, rsp.err);
        vpp_ok = 1;
        run(FSEPC_OP_ERASE);
        chk("status", 16'h0088, rsp.status);
        chk("fail", 1'h1, rsp.fail);
        chk("array_mode", 1'h1, array_mode);
        run(FSEPC_OP_CLEAR);
        run(FSEPC_OP_PROGRAM);
        chk("status", 16'h0080, rsp.status);
    endtask
    task automatic t_erase_fail;
        fail_next = 1;
        run(FSEPC_OP_ERASE);
        chk("err", FSEPC_ERR_ERASE, rsp.err);
        run(FSEPC_OP_PROGRAM);
        chk("err", FSEPC_ERR_SEQUENCE, rsp.err);
        fail_next = 0;
    endtask
    task automatic t_pdown;
        run(FSEPC_OP_POWERDOWN);
        chk("pd_n", 1'h0, fl_pd_n);
        run(FSEPC_OP_PROGRAM);
        chk("status", 16'h0080, rsp.status);
    endtask
    ////////////////////////////////////////////////////////////////
    // reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 0;
        t_prog_ok();
        t_prog_fail();
        t_vpp();
        t_erase_fail();
        t_pdown();
        finish_test();
    end
endmodule
